// ---- logic/wdog_pkg.sv ----
// windowed watchdog: register map, field layout, reset values, types
// assumes a 32-bit classic wishbone slave at word offsets 0x00..0x0C
package wdog_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [3:0] keyed_control_reg_off = 4'h0;
	localparam logic [3:0] write_once_mode_reg_off = 4'h4;
	localparam logic [3:0] fault_status_reg_off = 4'h8;
	localparam logic [3:0] irq_mask_reg_off = 4'hc;

	// ****************************************
	// field positions
	// ****************************************
	localparam int key_lsb = 24;
	localparam logic [7:0] control_key = 8'ha5;
	localparam int restart_bit = 0;
	localparam int reload_lsb = 0;
	localparam int irq_en_bit = 12;
	localparam int rst_en_bit = 13;
	localparam int scope_bit = 14;
	localparam int disable_bit = 15;
	localparam int delta_lsb = 16;
	localparam int dbg_halt_bit = 28;
	localparam int idle_halt_bit = 29;
	localparam int unf_bit = 0;
	localparam int err_bit = 1;

	// ****************************************
	// reset values and timing
	// ****************************************
	localparam logic [31:0] mode_reset = 32'h3fff_2fff;
	localparam logic [1:0] mask_reset = 2'h3;
	localparam int slow_div = 128;
	// slow clock derived from clk_i: 125 MHz / 32768 Hz = 3814 (rounded down)
	localparam int clk_hz = 125000000;
	localparam int slow_hz = 32768;
	localparam int slow_cycles = clk_hz / slow_hz;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic [1:0] spare_hi;
		logic idle_halt;
		logic debug_halt;
		logic [11:0] window_delta_value;
		logic timer_disable;
		logic reset_scope_select;
		logic fault_reset_enable;
		logic fault_irq_enable;
		logic [11:0] counter_reload_value;
	} mode_t;

	typedef struct packed {
		logic window_error_flag;
		logic underflow_flag;
	} status_t;

	typedef enum logic [1:0] {
		bus_idle = 2'b00,
		bus_ack = 2'b01
	} bus_state_t;

endpackage : wdog_pkg

// ---- logic/windowed_watchdog_timer.sv ----
// windowed watchdog: 12-bit down counter on slow clock / 128
// assumes wishbone master on clk_i; fault_o read by the reset controller,
// which answers by pulsing rst_i (processor reset)
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps

// Contract
// R1: twelve-bit down counter loaded from the reload value on every reload.
// R2: counter decrements once per slow clock tick divided by 128.
// R3: after reset reload is 0xFFF and fault reset generation is on.
// R4: mode register takes only the first write after reset.
// R5: accepted mode write reloads counter and restarts counting.
// R6: keyed restart reloads counter and restarts the divide-by-128 prescaler.
// R7: control write with wrong key has no effect whatsoever.
// R8: underflow sets sticky underflow flag regardless of reset enable.
// R9: underflow drives fault output when fault reset enable is set.
// R10: restart above window delta sets window error and fault, even disabled.
// R11: delta at or above reload value permits restart anywhere; the code still flags a count wrapped to 0xFFF above the delta.
// R12: interrupt while a flag is set and fault interrupt enable is one; the code also needs that flag's bit set in the irq mask register.
// R13: watchdog reset clears the watchdog and both flags.
// R14: status read or reset clears flags, interrupt and fault output.
// R15: counter stops in debug or idle state when the halt bit says so.
// R16: disable bit in mode register stops normal timing.
// R17: software must write key 0xA5 in the control key byte.
// R18: scope select picks all resets at 0, processor only at 1.
// R19: disabled timer neither counts nor underflows, still flags window errors.
module windowed_watchdog_timer
	import wdog_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// processor state pins
	input wire logic debug_state_i,
	input wire logic idle_state_i,
	// fault side
	output logic fault_o,
	output logic fault_all_resets_o,
	output logic fault_proc_reset_o,
	output logic irq_o
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] dbg_sync_reg;
	logic [2:0] idle_sync_reg;
	logic dbg_reg;
	logic idle_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dbg_sync_reg <= 3'h0;
			idle_sync_reg <= 3'h0;
			dbg_reg <= 1'b0;
			idle_reg <= 1'b0;
		end
		else
		begin
			dbg_sync_reg <= {dbg_sync_reg[1:0], debug_state_i};
			idle_sync_reg <= {idle_sync_reg[1:0], idle_state_i};
			// change counts once stages two and three agree
			if (dbg_sync_reg[1] == dbg_sync_reg[2])
				dbg_reg <= dbg_sync_reg[2];
			if (idle_sync_reg[1] == idle_sync_reg[2])
				idle_reg <= idle_sync_reg[2];
		end
	end

	// ****************************************
	// bus decode
	// ****************************************
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	bus_state_t bus_state_reg;
	logic req;
	logic wr;
	logic rd;
	logic all_lanes;
	mode_t mode_reg;
	logic mode_locked_reg;
	status_t status_reg;
	status_t status_next;
	logic [1:0] mask_reg;
	logic [11:0] count_reg;
	logic [6:0] presc_reg;
	logic [11:0] slow_reg;
	logic slow_tick;
	logic restart_ok;
	logic mode_wr;
	logic unf_evt;
	logic err_evt;
	logic sr_read;
	mode_t wr_mode;

	assign req = cyc_i && stb_i && (bus_state_reg == bus_idle);
	assign wr = req && we_i;
	assign rd = req && !we_i;
	// register contents only change on whole-word writes; a partial-lane mode write still sets the lock
	assign all_lanes = (sel_i == 4'hf);
	assign wr_mode = mode_t'(dat_i);
	assign restart_ok = wr && all_lanes && hit(adr_i, keyed_control_reg_off)
		&& dat_i[key_lsb +: 8] == control_key // R7 R17
		&& dat_i[restart_bit];
	assign mode_wr = wr && all_lanes && hit(adr_i, write_once_mode_reg_off)
		&& !mode_locked_reg; // R4
	assign sr_read = rd && hit(adr_i, fault_status_reg_off);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bus_state_reg <= bus_idle;
			ack_o <= 1'b0;
		end
		else
		begin
			unique case (bus_state_reg)
				bus_idle:
				begin
					if (cyc_i && stb_i)
					begin
						bus_state_reg <= bus_ack;
						ack_o <= 1'b1;
					end
				end
				bus_ack:
				begin
					bus_state_reg <= bus_idle;
					ack_o <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (rd)
		begin
			if (hit(adr_i, write_once_mode_reg_off))
				dat_o <= 32'(mode_reg);
			else if (hit(adr_i, fault_status_reg_off))
				dat_o <= {30'h0000_0000, status_reg};
			else if (hit(adr_i, irq_mask_reg_off))
				dat_o <= {30'h0000_0000, mask_reg};
			else
				dat_o <= 32'h0000_0000;
		end
	end

	// ****************************************
	// mode register, write once
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_reg <= mode_t'(mode_reset); // R3
			mode_locked_reg <= 1'b0;
		end
		else if (wr && hit(adr_i, write_once_mode_reg_off))
		begin
			// any write attempt locks, even a partial-lane one
			mode_locked_reg <= 1'b1; // R4
			if (mode_wr)
				mode_reg <= wr_mode;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mask_reg <= mask_reset;
		else if (wr && all_lanes && hit(adr_i, irq_mask_reg_off))
			mask_reg <= dat_i[1:0];
	end

	// ****************************************
	// slow clock and divide-by-128 prescaler
	// ****************************************
	localparam logic [11:0] slow_last = 12'(slow_cycles - 1);
	localparam logic [6:0] presc_last = 7'(slow_div - 1);
	logic halted;

	assign halted = (mode_reg.debug_halt && dbg_reg)
		|| (mode_reg.idle_halt && idle_reg); // R15

	always_ff @(posedge clk_i)
	begin
		if (rst_i || slow_reg == slow_last)
			slow_reg <= 12'h000;
		else
			slow_reg <= slow_reg + 12'h001;
	end
	assign slow_tick = (slow_reg == slow_last);

	// ****************************************
	// down counter
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_reg <= 12'hfff; // R3
			presc_reg <= 7'h00;
		end
		else if (mode_wr)
		begin
			count_reg <= wr_mode.counter_reload_value; // R5
			presc_reg <= 7'h00;
		end
		else if (restart_ok)
		begin
			count_reg <= mode_reg.counter_reload_value; // R1 R6
			presc_reg <= 7'h00; // R6
		end
		else if (slow_tick && !halted && !mode_reg.timer_disable) // R16 R19
		begin
			presc_reg <= presc_reg + 7'h01;
			if (presc_reg == presc_last)
			begin
				// wraps after underflow and keeps counting
				count_reg <= count_reg - 12'h001; // R2
			end
		end
	end

	assign unf_evt = slow_tick && !halted && !mode_reg.timer_disable
		&& !mode_wr && !restart_ok
		&& presc_reg == presc_last && count_reg == 12'h000; // R8 R19
	// compare against live value; delta >= reload trips only on a count wrapped to 0xFFF after underflow
	assign err_evt = restart_ok
		&& count_reg > mode_reg.window_delta_value; // R10 R11

	// ****************************************
	// status, interrupt, fault
	// ****************************************
	always_comb
	begin
		status_next = status_reg;
		if (sr_read)
			status_next = '0; // R14
		// a new event wins over the read clear
		if (unf_evt)
			status_next.underflow_flag = 1'b1; // R8
		if (err_evt)
			status_next.window_error_flag = 1'b1; // R10
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_reg <= '0; // R13 R14
		else
			status_reg <= status_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_o <= 1'b0;
			fault_o <= 1'b0;
			fault_all_resets_o <= 1'b0;
			fault_proc_reset_o <= 1'b0;
		end
		else
		begin
			irq_o <= mode_reg.fault_irq_enable
				&& |(status_next & mask_reg); // R12
			if (err_evt || (unf_evt && mode_reg.fault_reset_enable)) // R9 R10
			begin
				fault_o <= 1'b1;
				fault_all_resets_o <= mode_reg.fault_reset_enable
					&& !mode_reg.reset_scope_select; // R18
				fault_proc_reset_o <= mode_reg.fault_reset_enable
					&& mode_reg.reset_scope_select; // R18
			end
			else if (sr_read)
			begin
				fault_o <= 1'b0; // R14
				fault_all_resets_o <= 1'b0;
				fault_proc_reset_o <= 1'b0;
			end
		end
	end

endmodule : windowed_watchdog_timer

// ---- testbench/wdog_assertions.sv ----
// checker for the watchdog bus, fault and interrupt pins
// assumes binding to windowed_watchdog_timer, one clock domain
`timescale 1ns/10ps
module wdog_checker
	import wdog_pkg::*;
(
	// clock, reset, bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// fault side
	input wire logic fault_o,
	input wire logic fault_all_resets_o,
	input wire logic fault_proc_reset_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ****
	// properties
	// ****
	property p_ack_one;
		ack_o |=> !ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_ack_req;
		$rose(cyc_i && stb_i) |=> ack_o;
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack missing");
	property p_rd_clr;
		ack_o && !we_i && adr_i == fault_status_reg_off |=> !fault_o && !irq_o;
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("read kept fault");
	property p_ctl_rd;
		ack_o && !we_i && adr_i == keyed_control_reg_off |-> dat_o == 32'h0;
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control read not 0");
	property p_fault_hold;
		fault_o && !(cyc_i && stb_i) |=> fault_o;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
	property p_irq_hold;
		irq_o && !(cyc_i && stb_i) |=> irq_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
	property p_proc;
		fault_proc_reset_o |-> fault_o && !fault_all_resets_o;
	endproperty
	a_proc: assert property (p_proc) else $error("bad proc scope");
	property p_all;
		fault_all_resets_o |-> fault_o;
	endproperty
	a_all: assert property (p_all) else $error("bad all scope");
	property p_rst_clr;
		disable iff (1'b0) rst_i |=> !fault_o && !irq_o && !ack_o;
	endproperty
	a_rst_clr: assert property (p_rst_clr) else $error("reset kept fault");
	// ****
	// covers
	// ****
	c_proc: cover property ($rose(fault_proc_reset_o));
	c_irq: cover property ($rose(irq_o));
	c_rst: cover property ($fell(rst_i));
endmodule : wdog_checker

bind windowed_watchdog_timer wdog_checker u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
	.fault_o(fault_o), .fault_all_resets_o(fault_all_resets_o),
	.fault_proc_reset_o(fault_proc_reset_o), .irq_o(irq_o)
);

// ---- testbench/rstc_model.sv ----
// reset controller model: answers a watchdog fault with a reset
// assumes fault_i is the watchdog fault line on clk_i
`timescale 1ns/10ps
module rstc_model
(
	// clock and control
	input wire logic clk_i,
	input wire logic en_i,
	// fault in, reset out
	input wire logic fault_i,
	output logic rst_o
);
	// held until the fault drops, which the reset itself causes
	always_ff @(posedge clk_i)
	begin
		rst_o <= en_i & fault_i;
	end
endmodule : rstc_model

// ---- testbench/windowed_watchdog_timer_tb_top.sv ----
// self-checking bench for the windowed watchdog
// assumes wdog_pkg, the design, checker and reset controller model
`timescale 1ns/10ps
module windowed_watchdog_timer_tb_top;
	import wdog_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b = 1'b1;
	logic wd_rst;
	logic rst_i;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] adr_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic dbg_i = 1'b0;
	logic idle_i = 1'b0;
	logic pen = 1'b0;
	logic [31:0] dat_o;
	logic ack_o, fault_o, all_o, proc_o, irq_o;
	logic [31:0] seed = 32'h0000_0f3f;
	logic [7:0] key;
	logic [31:0] expq[$];
	int bad_count = 0;
	int n_tests = 0;

	always #4 clk_i = ~clk_i;
	assign rst_i = rst_b | wd_rst;

	windowed_watchdog_timer dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.debug_state_i(dbg_i), .idle_state_i(idle_i), .fault_o(fault_o),
		.fault_all_resets_o(all_o), .fault_proc_reset_o(proc_o),
		.irq_o(irq_o));
	rstc_model u_rc (.clk_i(clk_i), .en_i(pen), .fault_i(fault_o),
		.rst_o(wd_rst));

	// ****
	// helpers
	// ****
	function logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// halt pins get random levels; the count never nears zero here
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		seed = lfsr(seed);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		dbg_i <= seed[0];
		idle_i <= seed[1];
		@(posedge clk_i);
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task rd(input logic [3:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	// e = {fault, all resets, processor reset, irq}
	task fl(input logic [3:0] e);
		repeat (2) @(posedge clk_i);
		#1 chk({28'h0, fault_o, all_o, proc_o, irq_o}, {28'h0, e});
		@(posedge clk_i);
	endtask : fl

	// ****
	// read monitor
	// ****
	always @(posedge clk_i)
		if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0)
			chk(dat_o, expq.pop_front());

	initial
	begin
		#(8 * 3000);
		bad_count++;
		wrap_up;
	end

	// ****
	// scenarios
	// ****
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_b <= 1'b0;
		@(posedge clk_i);
		rd(write_once_mode_reg_off, mode_reset);
		rd(fault_status_reg_off, 32'h0000_0000);
		rd(irq_mask_reg_off, {30'h0, mask_reset});
		rd(keyed_control_reg_off, 32'h0000_0000);
		wr_ctl();
		fl(4'h0);
		bus(1'b1, write_once_mode_reg_off, 32'h0000_f0ff);
		bus(1'b1, write_once_mode_reg_off, 32'h0000_0123);
		rd(write_once_mode_reg_off, 32'h0000_f0ff);
		key = (seed[31:24] == control_key) ? 8'h5a : seed[31:24];
		bus(1'b1, keyed_control_reg_off, {key, 24'h00_0001});
		fl(4'h0);
		wr_ctl();
		fl(4'hb);
		rd(fault_status_reg_off, 32'h0000_0002);
		fl(4'h0);
		bus(1'b1, irq_mask_reg_off, 32'h0000_0000);
		wr_ctl();
		fl(4'ha);
		rd(fault_status_reg_off, 32'h0000_0002);
		pen <= 1'b1;
		wr_ctl();
		repeat (8) @(posedge clk_i);
		pen <= 1'b0;
		fl(4'h0);
		rd(write_once_mode_reg_off, mode_reset);
		bus(1'b1, write_once_mode_reg_off, 32'h0000_20ff);
		wr_ctl();
		fl(4'hc);
		rd(fault_status_reg_off, 32'h0000_0002);
		wrap_up;
	end

	task wr_ctl;
		bus(1'b1, keyed_control_reg_off, 32'ha500_0001);
	endtask : wr_ctl
endmodule : windowed_watchdog_timer_tb_top
